/* File: ramp_pkg.sv */
/*
 * Shared constants and types for the trapezoidal ramp pulse generator.
 * Assumes a single 40 MHz system clock and AHB-Lite register access.
 */
package ramp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned STEP_TIME_MS = 10;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int unsigned STEP_CYCLES = CYC_PER_MS * STEP_TIME_MS;
	localparam logic [15:0] STEPS_PER_S = 16'(MS_PER_S / STEP_TIME_MS);

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_RANGE = 4'h0;
	localparam logic [3:0] IDX_STEADY = 4'h1;
	localparam logic [3:0] IDX_INIT = 4'h2;
	localparam logic [3:0] IDX_RATE = 4'h3;
	localparam logic [3:0] IDX_DMODE = 4'h4;
	localparam logic [3:0] IDX_DSEL = 4'h5;
	localparam logic [3:0] IDX_PRE_HI = 4'h6;
	localparam logic [3:0] IDX_PRE_LO = 4'h7;
	localparam logic [3:0] IDX_CNT_HI = 4'h8;
	localparam logic [3:0] IDX_CNT_LO = 4'h9;
	localparam logic [3:0] IDX_ERR = 4'hA;
	localparam logic [3:0] IDX_STATUS = 4'hB;
	localparam logic [15:0] PARAM_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Parameter limits and scales
	// ----------------------------------------------------------------
	localparam logic [15:0] PCT_MAX = 16'h0064;
	localparam logic [15:0] X5_MAX = 16'h0014;
	localparam logic [15:0] HZ_MIN = 16'h000A;
	localparam logic [15:0] HZ_MAX = 16'h4E20;
	localparam logic [15:0] TIME_MIN = 16'h000A;
	localparam logic [15:0] TIME_MAX = 16'h2710;
	localparam logic [15:0] TIME_GRAIN = 16'h000A;
	localparam logic [31:0] PRESET_MAX = 32'h05F5E100;
	localparam logic [15:0] SCALE_R0 = 16'h000A;
	localparam logic [15:0] SCALE_R1 = 16'h0064;
	localparam logic [15:0] SCALE_R2 = 16'h03E8;

	// ----------------------------------------------------------------
	// Error codes
	// ----------------------------------------------------------------
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_RANGE = 16'h0001;
	localparam logic [15:0] ERR_INIT = 16'h0002;
	localparam logic [15:0] ERR_PRESET = 16'h0003;
	localparam logic [15:0] ERR_STEADY = 16'h0004;
	localparam logic [15:0] ERR_RATE = 16'h0005;
	localparam logic [15:0] ERR_DMODE = 16'h0006;
	localparam logic [15:0] ERR_DSEL = 16'h0007;
	localparam logic [15:0] ERR_RAMP_LEN = 16'h0008;
	localparam logic [15:0] ERR_INIT_HIGH = 16'h0009;
	localparam logic [15:0] ERR_RATE_HIGH = 16'h000A;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALC = 2'b01,
		ST_RUN = 2'b10
	} run_state_t;

	typedef enum logic [1:0] {
		PH_ACC = 2'b00,
		PH_STEADY = 2'b01,
		PH_DEC = 2'b10
	} ramp_phase_t;

	typedef struct packed {
		logic [15:0] range_sel;
		logic [15:0] steady_freq;
		logic [15:0] init_freq;
		logic [15:0] change_rate;
		logic [15:0] dir_mode;
		logic [15:0] dir_sel;
		logic [15:0] preset_hi;
		logic [15:0] preset_lo;
	} params_t;

	typedef struct packed {
		logic active;
		logic done;
		logic ramping;
		logic overflow;
	} flags_t;

endpackage

/* File: trapezoid_ramp_pulse_gen.sv */
/*
 * Trapezoidal ramp pulse generator with an AHB-Lite register slave.
 * Assumes start_in is asynchronous to hclk and that hclk is the only clock.
 */
// Summary of operation
// R1 - Ranges 0 and 1: init_freq 1 to 100 percent of range maximum.
// R2 - Range 2: init_freq 1 to 20, each unit five percent of maximum.
// R3 - Range 3: init_freq is hertz directly, 10 to 20000.
// R4 - Ranges 0 to 2: change_rate is a step per 10 ms.
// R5 - Range 3: change_rate is total ramp time, 10 to 10000 ms by tens.
// R6 - Acceleration and deceleration use the same rate or time.
// R7 - Mode 0: pulses on output a only, output b left free.
// R8 - Mode 1: pulses on a, b is direction level from dir_sel.
// R9 - Mode 2: forward pulses on a, reverse pulses on b.
// R10 - dir_mode changes after first start ignored until reset.
// R11 - dir_sel used only in modes 1 and 2; 0 forward, 1 reverse.
// R12 - Preset is preset_hi and preset_lo, valid 1 to 100000000.
// R13 - Running count shown in count_hi and count_lo, refreshed each cycle.
// R14 - Start validates parameters and writes err_code, zero meaning none.
// R15 - Codes 1 range, 2 initial, 4 steady, 5 rate or time.
// R16 - Code 3 for bad preset or zero ramp pulses in ranges 0 to 2.
// R17 - Code 6 for bad dir_mode, code 7 for bad dir_sel.
// R18 - Code 8 when ramp pulses exceed the preset total.
// R19 - Code 9 initial above steady; code 10 rate above their difference.
// R20 - flag_active high while generating; cleared by start drop or completion.
// R21 - flag_done set at completion or stop; cleared by next start.
// R22 - flag_ramping high while frequency changes, low at steady or idle.
// R23 - flag_overflow when exceeding preset, count held; cleared at start.
// R24 - Other parameter changes during generation apply at next start.
// R25 - Start drop stops pulses at once; next start begins at initial frequency.
// R26 - Deceleration starts when remaining pulses equal acceleration pulses.
module trapezoid_ramp_pulse_gen
	import ramp_pkg::*;
#(
	parameter int unsigned PHASE_MOD = CLK_HZ,
	parameter int unsigned STEP_CYC = STEP_CYCLES,
	parameter int unsigned MS_CYC = CYC_PER_MS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic start_in,
	output logic pulse_out_a,
	output logic pulse_out_b,
	output logic flag_active,
	output logic flag_done,
	output logic flag_ramping,
	output logic flag_overflow
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		params_t regs;
		params_t run;
		logic [1:0] dm_eff;
		logic dm_locked;
		logic [2:0] sync;
		logic start_lvl;
		run_state_t st;
		ramp_phase_t ph;
		logic [15:0] freq;
		logic [15:0] f_init;
		logic [15:0] f_steady;
		logic [15:0] f_step;
		logic [15:0] calc_f;
		logic [15:0] pend;
		logic [31:0] preset;
		logic [31:0] count;
		logic [31:0] accel_pulses;
		logic [31:0] ramp_sum;
		logic [31:0] phase_acc;
		logic [31:0] tick_cnt;
		logic lvl;
		logic [15:0] err;
		flags_t fl;
		logic out_a;
		logic out_b;
		logic a_ok;
		logic a_wr;
		logic [3:0] a_idx;
		logic [31:0] rdata;
		logic ready;
	} state_t;

	state_t r;
	state_t n;

	function automatic logic [15:0] to_hz(input logic [15:0] rs, input logic [15:0] v);
		logic [31:0] p;
		case (rs[1:0])
			2'd0: p = 32'(v) * 32'(SCALE_R0);
			2'd1: p = 32'(v) * 32'(SCALE_R1);
			2'd2: p = 32'(v) * 32'(SCALE_R2);
			default: p = 32'(v);
		endcase
		return p[15:0];
	endfunction

	function automatic logic val_ok(input logic [15:0] rs, input logic [15:0] v);
		if (rs == 16'h0003) begin
			return v >= HZ_MIN && v <= HZ_MAX;
		end
		return v != 16'h0000 && v <= ((rs == 16'h0002) ? X5_MAX : PCT_MAX);
	endfunction

	function automatic logic [15:0] check_params(input params_t p, input logic [15:0] dm);
		logic [31:0] pre;
		logic [15:0] ih;
		logic [15:0] sh;
		logic [15:0] rh;
		logic rate_ok;
		pre = {p.preset_hi, p.preset_lo}; // [R12]
		ih = to_hz(p.range_sel, p.init_freq); // [R1] [R2] [R3]
		sh = to_hz(p.range_sel, p.steady_freq);
		rh = to_hz(p.range_sel, p.change_rate); // [R4]
		if (p.range_sel == 16'h0003) begin
			rate_ok = p.change_rate >= TIME_MIN && p.change_rate <= TIME_MAX
				&& (p.change_rate % TIME_GRAIN) == 16'h0000; // [R5]
		end else begin
			rate_ok = val_ok(p.range_sel, p.change_rate);
		end
		if (p.range_sel > 16'h0003) return ERR_RANGE; // [R15]
		if (!val_ok(p.range_sel, p.init_freq)) return ERR_INIT; // [R15]
		if (!val_ok(p.range_sel, p.steady_freq)) return ERR_STEADY; // [R15]
		if (!rate_ok) return ERR_RATE; // [R15]
		if (dm > 16'h0002) return ERR_DMODE; // [R17]
		if ((dm == 16'h0001 || dm == 16'h0002) && p.dir_sel > 16'h0001) return ERR_DSEL; // [R11] [R17]
		if (pre == 32'h0 || pre > PRESET_MAX) return ERR_PRESET; // [R16]
		if (ih > sh) return ERR_INIT_HIGH; // [R19]
		if (p.range_sel != 16'h0003 && rh > sh - ih) return ERR_RATE_HIGH; // [R19]
		return ERR_NONE; // [R14]
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic start_rise;
	logic addr_ph;
	logic [15:0] dm_chk;
	logic [15:0] err_now;
	logic [47:0] need;
	logic [47:0] have;
	logic [31:0] psum;
	logic [31:0] tick_max;
	logic tick;
	logic [16:0] fwide;
	logic [31:0] rd_mux;

	always_comb begin
		n = r;
		n.sync = {r.sync[1:0], start_in};
		if (r.sync[1] == r.sync[2]) begin
			n.start_lvl = r.sync[2];
		end
		start_rise = (r.sync[1] == r.sync[2]) && r.sync[2] && !r.start_lvl;
		dm_chk = r.dm_locked ? 16'(r.dm_eff) : r.regs.dir_mode; // [R10]
		err_now = check_params(r.regs, dm_chk);
		need = 48'(17'(r.regs.init_freq) + 17'(r.regs.steady_freq)) * 48'(r.regs.change_rate);
		have = 48'({r.regs.preset_hi, r.regs.preset_lo}) * 48'(MS_PER_S);
		tick_max = (r.run.range_sel == 16'h0003) ? MS_CYC - 1 : STEP_CYC - 1;
		tick = r.tick_cnt >= tick_max;
		psum = r.phase_acc + 32'({r.freq, 1'b0});
		fwide = 17'h0;

		// Bus slave: read data is captured in the address phase, writes land in the data phase.
		addr_ph = hsel && htrans[1] && hready;
		case (haddr[5:2])
			IDX_RANGE: rd_mux = 32'(r.regs.range_sel);
			IDX_STEADY: rd_mux = 32'(r.regs.steady_freq);
			IDX_INIT: rd_mux = 32'(r.regs.init_freq);
			IDX_RATE: rd_mux = 32'(r.regs.change_rate);
			IDX_DMODE: rd_mux = 32'(r.regs.dir_mode);
			IDX_DSEL: rd_mux = 32'(r.regs.dir_sel);
			IDX_PRE_HI: rd_mux = 32'(r.regs.preset_hi);
			IDX_PRE_LO: rd_mux = 32'(r.regs.preset_lo);
			IDX_CNT_HI: rd_mux = 32'(r.count[31:16]); // [R13]
			IDX_CNT_LO: rd_mux = 32'(r.count[15:0]); // [R13]
			IDX_ERR: rd_mux = 32'(r.err);
			IDX_STATUS: rd_mux = 32'({r.fl.overflow, r.fl.ramping, r.fl.done, r.fl.active});
			default: rd_mux = 32'h0;
		endcase
		if (haddr[31:6] != 26'h0) begin
			rd_mux = 32'h0;
		end
		n.a_ok = addr_ph && haddr[31:6] == 26'h0;
		n.a_wr = hwrite;
		n.a_idx = haddr[5:2];
		if (addr_ph && !hwrite) begin
			n.rdata = rd_mux;
		end
		if (r.a_ok && r.a_wr) begin
			case (r.a_idx)
				IDX_RANGE: n.regs.range_sel = hwdata[15:0];
				IDX_STEADY: n.regs.steady_freq = hwdata[15:0];
				IDX_INIT: n.regs.init_freq = hwdata[15:0];
				IDX_RATE: n.regs.change_rate = hwdata[15:0];
				IDX_DMODE: n.regs.dir_mode = hwdata[15:0];
				IDX_DSEL: n.regs.dir_sel = hwdata[15:0];
				IDX_PRE_HI: n.regs.preset_hi = hwdata[15:0];
				IDX_PRE_LO: n.regs.preset_lo = hwdata[15:0];
				default: n.regs = r.regs;
			endcase
		end

		// Run control.
		case (r.st)
			ST_IDLE: begin
				if (start_rise) begin
					n.fl.done = 1'b0; // [R21]
					n.fl.overflow = 1'b0; // [R23]
					n.run = r.regs; // [R24]
					n.err = err_now; // [R14]
					if (!r.dm_locked) begin
						n.dm_locked = 1'b1; // [R10]
						n.dm_eff = r.regs.dir_mode[1:0];
					end
					n.f_init = to_hz(r.regs.range_sel, r.regs.init_freq);
					n.f_steady = to_hz(r.regs.range_sel, r.regs.steady_freq);
					n.f_step = to_hz(r.regs.range_sel, r.regs.change_rate);
					n.preset = {r.regs.preset_hi, r.regs.preset_lo}; // [R12]
					n.calc_f = n.f_init;
					n.ramp_sum = 32'h0;
					if (err_now == ERR_NONE) begin
						if (r.regs.range_sel != 16'h0003) begin
							n.st = ST_CALC;
						end else if (need > have) begin
							n.err = ERR_RAMP_LEN; // [R18]
						end else begin
							n.st = ST_RUN;
						end
					end
				end
			end
			ST_CALC: begin
				// Walks the up ramp once to count its pulses; the down ramp mirrors it.
				if (!r.start_lvl) begin
					n.st = ST_IDLE;
				end else if (r.calc_f >= r.f_steady) begin
					if (r.ramp_sum == 32'h0) begin
						n.err = ERR_PRESET; // [R16]
						n.st = ST_IDLE;
					end else if ({r.ramp_sum[30:0], 1'b0} > r.preset) begin
						n.err = ERR_RAMP_LEN; // [R18]
						n.st = ST_IDLE;
					end else begin
						n.st = ST_RUN;
					end
				end else begin
					n.ramp_sum = r.ramp_sum + 32'(r.calc_f / STEPS_PER_S);
					fwide = 17'(r.calc_f) + 17'(r.f_step);
					n.calc_f = (fwide > 17'(r.f_steady)) ? r.f_steady : fwide[15:0];
				end
			end
			ST_RUN: begin
				if (!r.start_lvl) begin
					n.st = ST_IDLE; // [R25]
					n.fl.active = 1'b0; // [R20]
					n.fl.done = 1'b1; // [R21]
					n.lvl = 1'b0; // [R25]
				end else begin
					n.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
					if (psum >= PHASE_MOD) begin
						n.phase_acc = psum - PHASE_MOD;
						n.lvl = !r.lvl;
						if (!r.lvl) begin
							if (r.count >= r.preset) begin
								n.fl.overflow = 1'b1; // [R23]
							end else begin
								n.count = r.count + 32'h1; // [R13]
								if (r.ph == PH_ACC) begin
									n.accel_pulses = r.accel_pulses + 32'h1;
								end
							end
						end else if (r.count >= r.preset) begin
							n.st = ST_IDLE;
							n.fl.active = 1'b0; // [R20]
							n.fl.done = 1'b1; // [R21]
						end
					end else begin
						n.phase_acc = psum;
					end
					if (r.ph != PH_DEC && r.preset - r.count <= r.accel_pulses) begin
						n.ph = PH_DEC; // [R26]
						n.pend = 16'h0;
					end else if (r.ph == PH_ACC) begin
						if (r.run.range_sel != 16'h0003) begin
							if (tick) begin
								fwide = 17'(r.freq) + 17'(r.f_step); // [R4]
								n.freq = (fwide >= 17'(r.f_steady)) ? r.f_steady : fwide[15:0];
							end
						end else if (tick) begin
							n.pend = r.pend + (r.f_steady - r.f_init); // [R5]
						end else if (r.pend >= r.run.change_rate) begin
							n.pend = r.pend - r.run.change_rate;
							n.freq = (r.freq < r.f_steady) ? r.freq + 16'h1 : r.f_steady;
						end
						if (n.freq >= r.f_steady) begin
							n.ph = PH_STEADY;
						end
					end else if (r.ph == PH_DEC) begin
						if (r.run.range_sel != 16'h0003) begin
							if (tick) begin
								fwide = 17'(r.f_init) + 17'(r.f_step); // [R6]
								n.freq = (17'(r.freq) > fwide) ? r.freq - r.f_step : r.f_init;
							end
						end else if (tick) begin
							n.pend = r.pend + (r.f_steady - r.f_init); // [R6]
						end else if (r.pend >= r.run.change_rate) begin
							n.pend = r.pend - r.run.change_rate;
							n.freq = (r.freq > r.f_init) ? r.freq - 16'h1 : r.f_init;
						end
					end
				end
			end
			default: n.st = ST_IDLE;
		endcase
		if (n.st == ST_RUN && r.st != ST_RUN) begin
			// Every run starts from the initial frequency with a fresh count.
			n.freq = n.f_init; // [R25]
			n.ph = PH_ACC;
			n.count = 32'h0;
			n.accel_pulses = 32'h0;
			n.phase_acc = 32'h0;
			n.tick_cnt = 32'h0;
			n.pend = 16'h0;
			n.lvl = 1'b0;
			n.fl.active = 1'b1; // [R20]
		end
		n.fl.ramping = n.fl.active && n.ph != PH_STEADY; // [R22]

		// Output steering; in mode 0 output b stays low for other use.
		case (n.dm_eff)
			2'd1: begin
				n.out_a = n.lvl && n.fl.active; // [R8]
				n.out_b = n.dm_locked && n.run.dir_sel[0]; // [R8] [R11]
			end
			2'd2: begin
				n.out_a = n.lvl && n.fl.active && !n.run.dir_sel[0]; // [R9]
				n.out_b = n.lvl && n.fl.active && n.run.dir_sel[0]; // [R9]
			end
			default: begin
				n.out_a = n.lvl && n.fl.active; // [R7]
				n.out_b = 1'b0; // [R7]
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.ready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign hrdata = r.rdata;
	assign hreadyout = r.ready;
	assign hresp = 1'b0;
	assign pulse_out_a = r.out_a;
	assign pulse_out_b = r.out_b;
	assign flag_active = r.fl.active;
	assign flag_done = r.fl.done;
	assign flag_ramping = r.fl.ramping;
	assign flag_overflow = r.fl.overflow;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_range_error: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
		(r.st == ST_IDLE && start_rise && r.regs.range_sel > 16'h0003) |=> r.err == ERR_RANGE)
		else $error("Bad range selector not reported.");
	a_count_capped: assert property (@(posedge hclk) disable iff (!hresetn) // [R23]
		r.fl.active |-> r.count <= r.preset)
		else $error("Running count passed the preset.");
	a_ramp_idle_low: assert property (@(posedge hclk) disable iff (!hresetn) // [R22]
		!r.fl.active |-> !r.fl.ramping)
		else $error("Ramping flag set while idle.");
	a_dual_exclusive: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
		r.dm_eff == 2'd2 |-> !(pulse_out_a && pulse_out_b))
		else $error("Both pulse outputs high in dual mode.");
	a_stop_on_drop: assert property (@(posedge hclk) disable iff (!hresetn) // [R25]
		(r.st == ST_RUN && !r.start_lvl) |=> (!flag_active && flag_done && !pulse_out_a) [*2])
		else $error("Start drop did not stop generation.");
	a_freq_bounds: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
		r.st == ST_RUN |-> (r.freq >= r.f_init && r.freq <= r.f_steady))
		else $error("Frequency left the initial to steady span.");
	a_done_cleared: assert property (@(posedge hclk) disable iff (!hresetn) // [R21]
		(r.st == ST_IDLE && start_rise) |=> !flag_done && !flag_overflow)
		else $error("Start did not clear completion flags.");
	a_mode_frozen: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
		(r.dm_locked && $past(r.dm_locked)) |-> $stable(r.dm_eff))
		else $error("Output mode changed after lock.");
	a_mode0_b_low: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
		(r.dm_eff == 2'd0) |-> !pulse_out_b)
		else $error("Output b driven in single mode.");

endmodule

/* File: drive_model.sv */
/*
 * Behavioural model of a stepper or servo drive with forward and reverse step inputs.
 * Assumes both inputs are registered levels that change on the system clock.
 */
module drive_model (
	input wire logic clk,
	input wire logic clr,
	input wire logic step_fwd,
	input wire logic step_rev,
	output int cnt_fwd,
	output int cnt_rev
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Edge counting
	// ------------------------------------------------------------
	// A real drive steps on each rising edge; the level alone carries no count.
	logic prev_fwd;
	logic prev_rev;

	initial begin
		prev_fwd = 1'b0;
		prev_rev = 1'b0;
		cnt_fwd = 0;
		cnt_rev = 0;
	end

	always @(posedge clk) begin
		if (clr) begin
			cnt_fwd <= 0;
			cnt_rev <= 0;
		end else begin
			if (step_fwd === 1'b1 && prev_fwd !== 1'b1)
				cnt_fwd <= cnt_fwd + 1;
			if (step_rev === 1'b1 && prev_rev !== 1'b1)
				cnt_rev <= cnt_rev + 1;
		end
		prev_fwd <= step_fwd;
		prev_rev <= step_rev;
	end
endmodule

/* File: trapezoid_ramp_pulse_gen_tb.sv */
/*
 * Self-checking bench for the trapezoidal ramp pulse generator.
 * Assumes the design's own assertions and a scaled phase modulus for short runs.
 */
module trapezoid_ramp_pulse_gen_tb
	import ramp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic hclk, hresetn, hsel, hwrite, start_in, clr, hready;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, pulse_out_a, pulse_out_b;
	logic flag_active, flag_done, flag_ramping, flag_overflow, saw_ramp;
	int cnt_a, cnt_b, fail_count, checks_done, cyc, ka, kb;
	assign hready = hreadyout;

	trapezoid_ramp_pulse_gen #(.PHASE_MOD(400000), .STEP_CYC(400), .MS_CYC(40)) u_dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.start_in(start_in), .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b),
		.flag_active(flag_active), .flag_done(flag_done), .flag_ramping(flag_ramping),
		.flag_overflow(flag_overflow));

	drive_model u_drive (.clk(hclk), .clr(clr), .step_fwd(pulse_out_a), .step_rev(pulse_out_b),
		.cnt_fwd(cnt_a), .cnt_rev(cnt_b));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One single-word transfer; the wait lasts as long as the slave holds hready low.
	task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {26'h0000000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic cfg(input logic [15:0] r, s, i, c, m, d, p);
		bus(1'b1, IDX_RANGE, {16'h0000, r});
		bus(1'b1, IDX_STEADY, {16'h0000, s});
		bus(1'b1, IDX_INIT, {16'h0000, i});
		bus(1'b1, IDX_RATE, {16'h0000, c});
		bus(1'b1, IDX_DMODE, {16'h0000, m});
		bus(1'b1, IDX_DSEL, {16'h0000, d});
		bus(1'b1, IDX_PRE_HI, 32'h00000000);
		bus(1'b1, IDX_PRE_LO, {16'h0000, p});
	endtask

	task automatic do_reset();
		start_in <= 1'b0;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask

	task automatic set_start(input logic v, input int n);
		@(posedge hclk);
		start_in <= v;
		repeat (n) @(posedge hclk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		for (int k = 0; k < 12; k++) begin
			bus(1'b0, 4'(k), 32'h00000000);
			chk(rdv, 32'h00000000);
		end
		bus(1'b0, 4'hC, 32'h00000000);
		chk(rdv, 32'h00000000);
		bus(1'b1, IDX_ERR, 32'h00000005);
		bus(1'b0, IDX_ERR, 32'h00000000);
		chk(rdv, 32'h00000000);
		chk({31'h0, hresp}, 32'h00000000);
		$display("test registers done");
	endtask

	task automatic t_errors();
		logic [3:0] fi [9] = '{IDX_RANGE, IDX_INIT, IDX_STEADY, IDX_RATE, IDX_DMODE, IDX_DSEL,
			IDX_PRE_LO, IDX_INIT, IDX_PRE_LO};
		logic [15:0] fv [9] = '{16'h0004, 16'h0005, 16'h0005, 16'h000F, 16'h0003, 16'h0002,
			16'h0000, 16'h0BB8, 16'h001D};
		logic [15:0] fe [9] = '{ERR_RANGE, ERR_INIT, ERR_STEADY, ERR_RATE, ERR_DMODE, ERR_DSEL,
			ERR_PRESET, ERR_INIT_HIGH, ERR_RAMP_LEN};
		for (int k = 0; k < 9; k++) begin
			do_reset();
			cfg(16'h0003, 16'h07D0, 16'h03E8, 16'h000A, (k == 5) ? 16'h0001 : 16'h0000, 16'h0000, 16'h001E);
			bus(1'b1, fi[k], {16'h0000, fv[k]});
			set_start(1'b1, 150);
			bus(1'b0, IDX_ERR, 32'h00000000);
			chk(rdv, {16'h0000, fe[k]});
			chk({31'h0, flag_active}, 32'h00000000);
			set_start(1'b0, 8);
		end
		$display("test error codes done");
	endtask

	task automatic t_ranges();
		logic [15:0] rr [3] = '{16'h0000, 16'h0001, 16'h0002};
		logic [15:0] rs [3] = '{16'h0002, 16'h001E, 16'h0004};
		logic [15:0] ri [3] = '{16'h0001, 16'h000A, 16'h0001};
		logic [15:0] rc [3] = '{16'h0001, 16'h0019, 16'h0001};
		logic [15:0] re [3] = '{ERR_PRESET, ERR_RATE_HIGH, ERR_NONE};
		for (int k = 0; k < 3; k++) begin
			cfg(rr[k], rs[k], ri[k], rc[k], 16'h0000, 16'h0000, 16'h00C8);
			set_start(1'b1, 150);
			bus(1'b0, IDX_ERR, 32'h00000000);
			chk(rdv, {16'h0000, re[k]});
			chk({30'h0, flag_active, flag_ramping}, (k == 2) ? 32'h00000003 : 32'h00000000);
			set_start(1'b0, 8);
		end
		chk({31'h0, flag_done}, 32'h00000001);
		$display("test frequency ranges done");
	endtask

	task automatic wait_done();
		saw_ramp = 1'b0;
		for (int n = 0; n < 20000 && flag_done !== 1'b1; n++) begin
			@(posedge hclk);
			if (flag_ramping === 1'b1)
				saw_ramp = 1'b1;
		end
	endtask

	task automatic t_mode(input logic [15:0] m, input int ea, input int eb);
		do_reset();
		cfg(16'h0003, 16'h07D0, 16'h03E8, 16'h000A, m, 16'h0001, 16'h001E);
		@(posedge hclk);
		clr <= 1'b1;
		@(posedge hclk);
		clr <= 1'b0;
		set_start(1'b1, 10);
		bus(1'b1, IDX_PRE_LO, 32'h00000005);
		wait_done();
		repeat (4) @(posedge hclk);
		chk(32'(cnt_a), 32'(ea));
		chk(32'(cnt_b), 32'(eb));
		chk({28'h0, flag_active, flag_done, flag_overflow, saw_ramp}, 32'h00000005);
		chk({31'h0, flag_ramping}, 32'h00000000);
		bus(1'b0, IDX_CNT_LO, 32'h00000000);
		chk(rdv, 32'h0000001E);
		bus(1'b0, IDX_ERR, 32'h00000000);
		chk(rdv, 32'h00000000);
		set_start(1'b0, 8);
		$display("test output mode %0d done", m);
	endtask

	task automatic t_abort();
		bus(1'b1, IDX_DMODE, 32'h00000000);
		bus(1'b1, IDX_PRE_LO, 32'h0000001E);
		@(posedge hclk);
		clr <= 1'b1;
		@(posedge hclk);
		clr <= 1'b0;
		set_start(1'b1, 10);
		chk({31'h0, flag_done}, 32'h00000000);
		for (int n = 0; n < 5000 && cnt_b < 5; n++)
			@(posedge hclk);
		set_start(1'b0, 8);
		chk({30'h0, flag_active, flag_done}, 32'h00000001);
		ka = cnt_a;
		kb = cnt_b;
		repeat (800) @(posedge hclk);
		chk(32'(cnt_b), 32'(kb));
		chk(32'(ka), 32'h00000000);
		chk(32'(kb >= 5), 32'h00000001);
		$display("test abort done");
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// Four runs of at most about seven thousand cycles each plus the error loop fit well inside this.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		start_in = 1'b0;
		clr = 1'b0;
		fail_count = 0;
		checks_done = 0;
		cyc = 0;
		do_reset();
		t_regs();
		t_errors();
		t_ranges();
		t_mode(16'h0000, 30, 0);
		t_mode(16'h0001, 30, 1);
		t_mode(16'h0002, 0, 30);
		t_abort();
		close_out();
	end
endmodule
